//--- rc_osc_pkg.sv
package rc_osc_pkg;

  localparam int ADDR_W = 7;
  localparam int DATA_W = 4;
  localparam int ACC_W  = 24;

  // Register offsets.
  localparam logic [ADDR_W-1:0] OFS_TRIM_HI = 7'h75;
  localparam logic [ADDR_W-1:0] OFS_TRIM_LO = 7'h76;
  localparam logic [ADDR_W-1:0] OFS_OPT0    = 7'h79;
  localparam logic [ADDR_W-1:0] OFS_FREQ    = 7'h7a;
  localparam logic [ADDR_W-1:0] OFS_OPT2    = 7'h7b;

  // Power-on reset values.
  localparam logic [DATA_W-1:0] RST_TRIM_HI = 4'h7;
  localparam logic [DATA_W-1:0] RST_TRIM_LO = 4'hf;
  localparam logic [DATA_W-1:0] RST_OPT0    = 4'h0;
  localparam logic [DATA_W-1:0] RST_FREQ    = 4'h0;
  localparam logic [DATA_W-1:0] RST_OPT2    = 4'h0;
  localparam logic [7:0]        TRIM_CENTER = 8'h7f;

  // Field positions.
  localparam int FREQ_BASE_BIT = 3;
  localparam int OPT0_DEB_BIT  = 3;
  localparam int OPT0_RSV_BIT  = 2;
  localparam int OPT0_CNT_BIT  = 1;
  localparam int OPT0_PULL_BIT = 0;
  localparam int OPT2_TOP_BIT  = 0;

  // Timing: the oscillator is modelled as a phase accumulator on the core clock.
  localparam longint CLK_HZ     = 100_000_000;
  localparam longint BASE_LO_HZ = 512_000;
  localparam longint BASE_HI_HZ = 800_000;
  // One accumulator carry per half period of the undivided base clock.
  localparam logic [ACC_W-1:0] INC_LO = ACC_W'(((2 * BASE_LO_HZ) << ACC_W) / CLK_HZ);
  localparam logic [ACC_W-1:0] INC_HI = ACC_W'(((2 * BASE_HI_HZ) << ACC_W) / CLK_HZ);
  localparam logic [ACC_W-1:0] TRIM_STEP_DEF = 24'h000020;

  // Divider codes of the frequency selection.
  localparam logic [2:0] DIV16 = 3'h0;
  localparam logic [2:0] DIV8  = 3'h1;
  localparam logic [2:0] DIV4  = 3'h2;
  localparam logic [2:0] DIV2  = 3'h3;
  localparam logic [2:0] DIV1  = 3'h4;

  function automatic logic [4:0] half_ticks(input logic [2:0] code);
    logic [4:0] n;
    n = 5'h01;
    case (code)
      DIV16:   n = 5'h10;
      DIV8:    n = 5'h08;
      DIV4:    n = 5'h04;
      DIV2:    n = 5'h02;
      DIV1:    n = 5'h01;
      default: n = 5'h01;
    endcase
    return n;
  endfunction

endpackage

//--- rc_osc_option_control.sv
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps

// Overview of operation
// R1: After power-up the oscillator runs at 32 kHz until software selects otherwise.
// R2: Frequency select bit 3 picks the 512 kHz or 800 kHz base.
// R3: Frequency select bits 2..0 divide the base by 16, 8, 4, 2 or 1.
// R4: Trim word is high and low nibble, default 7Fh, -127 to +128 steps.
// R5: Larger trim word gives higher frequency, monotonic over the whole range.
// R6: Option 0 bit 3 picks debouncer tap: 0 tap a, 1 tap b.
// R7: Software keeps option 0 bit 2 at zero and never writes one.
// R8: Option 0 bit 1 picks counter source 7: pin, or halved oscillator clock.
// R9: With halved oscillator source, counter updates on core clock, not system tap.
// R10: Oscillator source 7 is core clock over 4 when bypass is 1, else over 2.
// R11: By default counter updates on system clock, at most half its rate.
// R12: Option 0 bit 0 sets port pin 4 resistor: 0 pull-down, 1 pull-up.
// R13: Option 2 bit 0 sets detector level 15 to 2.75 V or 3.0 V.
// R14: Software keeps system clock near 32 or 50 kHz when changing frequency.
// R15: These registers reset only on power-on reset, not on other resets.
// R16: Undefined divider codes are harmless and never stop the clock.
// R17: Frequency and trim changes take effect without runt clock pulses.
module rc_osc_option_control
  import rc_osc_pkg::*;
#(
  parameter logic [ACC_W-1:0] TRIM_STEP = TRIM_STEP_DEF
)
(
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  input  wire logic              wr_en_i,
  input  wire logic              rd_en_i,
  output logic      [DATA_W-1:0] rd_data_o,
  input  wire logic              core_clock_en_i,
  input  wire logic              prescaler_sys_tap_i,
  input  wire logic              prescaler_tap_a_i,
  input  wire logic              prescaler_tap_b_i,
  input  wire logic              port_debounce_bypass_i,
  input  wire logic              port_pin_3_or_4_i,
  output logic                   osc_clock_o,
  output logic                   osc_clock_rise_o,
  output logic      [DATA_W-1:0] osc_freq_active_o,
  output logic      [7:0]        osc_trim_word_o,
  output logic                   debounce_clk_en_o,
  output logic                   counter_update_o,
  output logic                   counter_src7_o,
  output logic                   port_pin_4_pull_up_o,
  output logic                   top_level_option_o
);

  // The trim range must never push the lower base increment to zero or wrap it.
  if ((TRIM_STEP == '0) || ((longint'(TRIM_STEP) * 127) >= longint'(INC_LO))
      || ((longint'(INC_HI) + longint'(TRIM_STEP) * 128) >= (longint'(1) << ACC_W)))
  begin : g_step_check
    $error("TRIM_STEP out of range for the accumulator");
  end

  typedef struct packed {
    logic [DATA_W-1:0] trim_hi;
    logic [DATA_W-1:0] trim_lo;
    logic [DATA_W-1:0] opt0;
    logic [DATA_W-1:0] freq;
    logic [DATA_W-1:0] opt2;
    logic [DATA_W-1:0] rd;
    logic [ACC_W-1:0]  acc;
    logic [DATA_W-1:0] act_freq;
    logic [7:0]        act_trim;
    logic [4:0]        div_cnt;
    logic              osc;
    logic              osc_rise;
    logic              pin_s1;
    logic              pin_s2;
    logic              src7;
    logic              core_ph;
    logic              dbc_en;
    logic              cnt_upd;
  } state_t;

  state_t            q;
  state_t            d;
  logic [ACC_W-1:0]  inc;
  logic [ACC_W:0]    sum;
  logic              base_tick;

  always_comb
  begin
    d           = q;
    d.rd        = '0;
    d.osc_rise  = 1'b0;
    inc         = '0;
    sum         = '0;
    base_tick   = 1'b0;

    // Register writes; all fields are kept as written.
    if (wr_en_i)
    begin
      case (addr_i)
        OFS_TRIM_HI: d.trim_hi = wr_data_i; // R4
        OFS_TRIM_LO: d.trim_lo = wr_data_i; // R4
        // Bit 2 is stored as written; keeping it low is up to software.
        OFS_OPT0:    d.opt0 = wr_data_i; // R7
        OFS_FREQ:    d.freq = wr_data_i;
        OFS_OPT2:    d.opt2 = wr_data_i;
        default:     d.opt0 = q.opt0;
      endcase
    end

    // Reads answer in the following cycle; unmapped offsets read zero.
    if (rd_en_i)
    begin
      case (addr_i)
        OFS_TRIM_HI: d.rd = q.trim_hi;
        OFS_TRIM_LO: d.rd = q.trim_lo;
        OFS_OPT0:    d.rd = q.opt0;
        OFS_FREQ:    d.rd = q.freq;
        OFS_OPT2:    d.rd = q.opt2;
        default:     d.rd = '0;
      endcase
    end

    // Base oscillator: the increment grows linearly with the trim word,
    // so the frequency is monotonic in it and centred on 7Fh.
    inc = (q.act_freq[FREQ_BASE_BIT] ? INC_HI : INC_LO) // R2
          + ACC_W'(q.act_trim) * TRIM_STEP              // R5
          - ACC_W'(TRIM_CENTER) * TRIM_STEP;            // R4
    sum       = {1'b0, q.acc} + {1'b0, inc};
    d.acc     = sum[ACC_W-1:0];
    base_tick = sum[ACC_W];

    // Divider: the output toggles after a full half period of base ticks.
    // New selections are taken only at a toggle, so every half period is
    // wholly at the old or wholly at the new setting and no runt appears.
    if (base_tick)
    begin
      if (q.div_cnt >= half_ticks(q.act_freq[2:0]) - 5'h01) // R3 R16
      begin
        d.div_cnt  = '0;
        d.osc      = ~q.osc;
        d.osc_rise = ~q.osc;
        d.act_freq = q.freq;                   // R17
        d.act_trim = {q.trim_hi, q.trim_lo};   // R17
      end
      else
      begin
        d.div_cnt = q.div_cnt + 5'h01;
      end
    end

    // Pin input crosses into the clock domain through two flip-flops.
    d.pin_s1 = port_pin_3_or_4_i;
    d.pin_s2 = q.pin_s1;

    // Counter source 7: the pin, or a clock derived from the core clock.
    if (!q.opt0[OPT0_CNT_BIT])
    begin
      d.src7    = q.pin_s2; // R8
      d.core_ph = 1'b0;
    end
    else if (core_clock_en_i)
    begin
      if (port_debounce_bypass_i)
      begin
        d.core_ph = ~q.core_ph;
        if (q.core_ph)
        begin
          d.src7 = ~q.src7; // R10
        end
      end
      else
      begin
        d.core_ph = 1'b0;
        d.src7    = ~q.src7; // R10
      end
    end

    // Update strobe of the counter: core clock when sampling the halved
    // oscillator, otherwise the system clock tap.
    d.cnt_upd = q.opt0[OPT0_CNT_BIT] ? core_clock_en_i     // R9
                                     : prescaler_sys_tap_i; // R11

    d.dbc_en = q.opt0[OPT0_DEB_BIT] ? prescaler_tap_b_i : prescaler_tap_a_i; // R6
  end

  // Only the power-on reset clears this state; a watchdog reset elsewhere in
  // the chip does not reach this block.
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      q          <= '0;
      q.trim_hi  <= RST_TRIM_HI;         // R15
      q.trim_lo  <= RST_TRIM_LO;         // R15
      q.opt0     <= RST_OPT0;            // R15
      q.freq     <= RST_FREQ;            // R1
      q.opt2     <= RST_OPT2;            // R15
      q.act_freq <= RST_FREQ;            // R1
      q.act_trim <= {RST_TRIM_HI, RST_TRIM_LO};
    end
    else
    begin
      q <= d;
    end
  end

  assign rd_data_o            = q.rd;
  assign osc_clock_o          = q.osc;
  assign osc_clock_rise_o     = q.osc_rise;
  assign osc_freq_active_o    = q.act_freq;
  assign osc_trim_word_o      = q.act_trim;
  assign debounce_clk_en_o    = q.dbc_en;
  assign counter_update_o     = q.cnt_upd;
  assign counter_src7_o       = q.src7;
  assign port_pin_4_pull_up_o = q.opt0[OPT0_PULL_BIT]; // R12
  assign top_level_option_o   = q.opt2[OPT2_TOP_BIT];  // R13

  // Helper for the checks below: base ticks seen since the last toggle.
  logic [4:0] tick_cnt;
  logic       osc_prev;

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      tick_cnt <= '0;
      osc_prev <= 1'b0;
    end
    else
    begin
      osc_prev <= q.osc;
      if (base_tick && (d.osc != q.osc))
      begin
        tick_cnt <= '0;
      end
      else if (base_tick)
      begin
        tick_cnt <= tick_cnt + 5'h01;
      end
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  a_power_on_freq: assert property ( // R1
    !$past(reset_n_i) |-> (q.freq == RST_FREQ) && (q.act_freq == RST_FREQ))
    else $error("Oscillator does not start at the lowest setting.");

  a_trim_default: assert property ( // R4
    !$past(reset_n_i) |-> (osc_trim_word_o == TRIM_CENTER))
    else $error("Trim word does not start at its centre value.");

  a_half_period: assert property ( // R3
    (q.osc != osc_prev) |-> ($past(tick_cnt) + 5'h01 == half_ticks($past(q.act_freq[2:0]))))
    else $error("Half period does not match the applied divider.");

  a_base_select: assert property ( // R2
    (q.act_freq[FREQ_BASE_BIT] && (q.act_trim == TRIM_CENTER)) |-> (inc == INC_HI))
    else $error("Base increment does not follow the base select bit.");

  a_trim_monotonic: assert property ( // R5
    ($stable(q.act_freq[FREQ_BASE_BIT]) && (q.act_trim > $past(q.act_trim))) |-> (inc > $past(inc)))
    else $error("A larger trim word did not raise the frequency.");

  a_change_at_edge: assert property ( // R17
    $changed(q.act_freq) |-> (q.osc != osc_prev) && (q.div_cnt == 5'h00))
    else $error("Frequency selection applied inside a half period.");

  a_debounce_tap: assert property ( // R6
    debounce_clk_en_o == $past(q.opt0[OPT0_DEB_BIT] ? prescaler_tap_b_i : prescaler_tap_a_i))
    else $error("Debouncer enable does not follow the selected tap.");

  a_src7_pin: assert property ( // R8
    (!q.opt0[OPT0_CNT_BIT] ##1 !q.opt0[OPT0_CNT_BIT]) |-> (counter_src7_o == $past(q.pin_s2)))
    else $error("Counter source 7 does not follow the port pin.");

  a_src7_core: assert property ( // R10
    ($past(q.opt0[OPT0_CNT_BIT]) && q.opt0[OPT0_CNT_BIT] && $changed(counter_src7_o))
    |-> $past(core_clock_en_i) && (!$past(port_debounce_bypass_i) || $past(q.core_ph)))
    else $error("Counter source 7 toggled off the core clock division.");

  a_update_source: assert property ( // R9
    counter_update_o == $past(q.opt0[OPT0_CNT_BIT] ? core_clock_en_i : prescaler_sys_tap_i))
    else $error("Counter update strobe took the wrong clock.");

  a_pull_write: assert property ( // R12
    (wr_en_i && (addr_i == OFS_OPT0)) |=> (port_pin_4_pull_up_o == $past(wr_data_i[OPT0_PULL_BIT])))
    else $error("Pull direction does not follow the written bit.");

  a_top_level: assert property ( // R13
    (wr_en_i && (addr_i == OFS_OPT2)) |=> (top_level_option_o == $past(wr_data_i[OPT2_TOP_BIT])))
    else $error("Detector level option does not follow the written bit.");

  a_read_data: assert property ( // R2
    (rd_en_i && (addr_i == OFS_FREQ)) |=> (rd_data_o == $past(q.freq)))
    else $error("Read data of the frequency register is wrong.");

  // Read data stand for one cycle only, so a stale value cannot be mistaken for an answer.
  a_read_idle_zero: assert property (
    !rd_en_i |=> (rd_data_o == '0))
    else $error("Read data present without a read strobe.");

  a_trim_read: assert property ( // R4
    (rd_en_i && (addr_i == OFS_TRIM_HI)) |=> (rd_data_o == $past(q.trim_hi)))
    else $error("Read data of the high trim nibble is wrong.");

  a_opt0_read: assert property ( // R6
    (rd_en_i && (addr_i == OFS_OPT0)) |=> (rd_data_o == $past(q.opt0)))
    else $error("Read data of option register 0 is wrong.");

  a_freq_write: assert property ( // R2
    (wr_en_i && (addr_i == OFS_FREQ)) |=> (q.freq == $past(wr_data_i)))
    else $error("Frequency selection does not hold the written value.");

  a_trim_write: assert property ( // R4
    (wr_en_i && (addr_i == OFS_TRIM_LO)) |=> (q.trim_lo == $past(wr_data_i)))
    else $error("Low trim nibble does not hold the written value.");

  a_trim_applied: assert property ( // R17
    $changed(q.act_trim) |-> (q.act_trim == $past({q.trim_hi, q.trim_lo})) && (q.osc != osc_prev))
    else $error("Trim word applied off a toggle or with a wrong value.");

  a_rise_pulse: assert property ( // R3
    osc_clock_rise_o == $rose(osc_clock_o))
    else $error("Rise pulse does not match the oscillator edge.");

  a_rise_single: assert property ( // R17
    osc_clock_rise_o |=> !osc_clock_rise_o)
    else $error("Rise pulse lasted longer than one cycle.");

  a_fast_code_toggle: assert property ( // R16
    (base_tick && (q.act_freq[2:0] >= DIV1)) |=> (q.osc != osc_prev))
    else $error("Undivided or undefined code did not toggle on a base tick.");

  a_src7_hold: assert property ( // R10
    (q.opt0[OPT0_CNT_BIT] && !core_clock_en_i) |=> $stable(counter_src7_o))
    else $error("Counter source 7 moved without a core clock enable.");

  a_reset_outputs: assert property ( // R15
    !$past(reset_n_i) |-> !osc_clock_o && !osc_clock_rise_o && (rd_data_o == '0))
    else $error("Outputs not at their reset values after reset.");

endmodule

//--- rc_osc_option_control_test.sv
`timescale 1ns/1ps
module rc_osc_option_control_test;
  import rc_osc_pkg::*;

  logic              clk_i      = 1'b0;
  logic              reset_n_i  = 1'b0;
  logic [ADDR_W-1:0] addr_i     = '0;
  logic [DATA_W-1:0] wr_data_i  = '0;
  logic              wr_en_i    = 1'b0;
  logic              rd_en_i    = 1'b0;
  logic [3:0]        taps       = '0;
  logic              bypass     = 1'b0;
  logic              pin        = 1'b0;
  logic [DATA_W-1:0] rd_data_o;
  logic [DATA_W-1:0] freq_act;
  logic [7:0]        trim_o;
  logic              osc_clk;
  logic              rise;
  logic              deb;
  logic              upd;
  logic              src7;
  logic              pull_up;
  logic              top_lvl;
  int                num_errors = 0;
  int                checked    = 0;
  int                cycles     = 0;

  rc_osc_option_control u_rc_osc_option_control (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
    .core_clock_en_i(taps[3]), .prescaler_sys_tap_i(taps[2]),
    .prescaler_tap_a_i(taps[1]), .prescaler_tap_b_i(taps[0]),
    .port_debounce_bypass_i(bypass), .port_pin_3_or_4_i(pin),
    .osc_clock_o(osc_clk), .osc_clock_rise_o(rise), .osc_freq_active_o(freq_act),
    .osc_trim_word_o(trim_o), .debounce_clk_en_o(deb), .counter_update_o(upd),
    .counter_src7_o(src7), .port_pin_4_pull_up_o(pull_up), .top_level_option_o(top_lvl)
  );

  always #5 clk_i = ~clk_i;

  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // The full frequency sweep needs about 40000 cycles at the slowest settings.
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      num_errors++;
      final_report();
    end
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    wr_en_i   <= 1'b1;
    addr_i    <= a;
    wr_data_i <= d;
    @(posedge clk_i);
    wr_en_i   <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clk_i);
    rd_en_i <= 1'b1;
    addr_i  <= a;
    @(posedge clk_i);
    rd_en_i <= 1'b0;
    #1;
    check("read data", 16'(rd_data_o), 16'(exp));
  endtask

  task automatic pulse(input logic [3:0] v);
    @(posedge clk_i);
    taps <= v;
    @(posedge clk_i);
    taps <= 4'h0;
    #1;
  endtask

  task automatic do_reset();
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'b1;
  endtask

  // Counts clock cycles from the call up to the n-th oscillator rise; whole periods only when started just after a rise.
  task automatic measure(input int n, output int c);
    int k;
    k = 0;
    c = 0;
    while (k < n)
    begin
      @(posedge clk_i);
      c++;
      if (rise === 1'b1)
      begin
        k++;
        check("clock high at rise", 16'(osc_clk), 16'h0001);
      end
    end
  endtask

  task automatic t_reset_values();
    check("trim word", 16'(trim_o), 16'h007f);
    check("active freq", 16'(freq_act), 16'h0000);
    rd(OFS_TRIM_HI, 4'h7);
    rd(OFS_TRIM_LO, 4'hf);
    rd(OFS_OPT0, 4'h0);
    rd(OFS_FREQ, 4'h0);
    rd(OFS_OPT2, 4'h0);
    rd(7'h77, 4'h0);
  endtask

  task automatic t_options();
    wr(OFS_OPT0, 4'h9);
    wr(OFS_OPT2, 4'h1);
    check("pull up", 16'(pull_up), 16'h0001);
    check("top level", 16'(top_lvl), 16'h0001);
    rd(OFS_OPT0, 4'h9);
    wr(OFS_OPT0, 4'h0);
    wr(OFS_OPT2, 4'h0);
    check("pull down", 16'(pull_up), 16'h0000);
    check("low level", 16'(top_lvl), 16'h0000);
  endtask

  task automatic t_debounce();
    for (int s = 0; s < 2; s++)
    begin
      wr(OFS_OPT0, {s[0], 3'h0});
      pulse(4'h2);
      check("tap a", 16'(deb), 16'(!s[0]));
      pulse(4'h1);
      check("tap b", 16'(deb), 16'(s[0]));
    end
  endtask

  task automatic t_counter();
    logic s;
    wr(OFS_OPT0, 4'h0);
    pulse(4'h4);
    check("sys update", 16'(upd), 16'h0001);
    pulse(4'h8);
    check("core ignored", 16'(upd), 16'h0000);
    @(posedge clk_i);
    pin <= 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    check("pin source", 16'(src7), 16'h0001);
    wr(OFS_OPT0, 4'h2);
    pulse(4'h8);
    check("core update", 16'(upd), 16'h0001);
    pulse(4'h4);
    check("sys ignored", 16'(upd), 16'h0000);
    s = src7;
    pulse(4'h8);
    check("half rate", 16'(src7), 16'(!s));
    @(posedge clk_i);
    bypass <= 1'b1;
    s = src7;
    pulse(4'h8);
    pulse(4'h8);
    check("quarter rate a", 16'(src7), 16'(!s));
    pulse(4'h8);
    pulse(4'h8);
    check("quarter rate b", 16'(src7), 16'(s));
  endtask

  task automatic t_freq();
    logic [3:0] codes[11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'h7};
    longint hz;
    longint exp;
    int c;
    foreach (codes[i])
    begin
      wr(OFS_FREQ, codes[i]);
      hz  = (codes[i][3] ? BASE_HI_HZ : BASE_LO_HZ) >> ((codes[i][2:0] > 3'h4) ? 0 : 4 - codes[i][2:0]);
      exp = 2 * CLK_HZ / hz;
      measure(2, c);
      measure(2, c);
      check("active freq", 16'(freq_act), 16'(codes[i]));
      check("period", 16'(c * 100 >= exp * 98 && c * 100 <= exp * 102), 16'h0001);
    end
  endtask

  task automatic t_trim();
    int c;
    int c0;
    int c1;
    wr(OFS_FREQ, 4'hc);
    wr(OFS_TRIM_HI, 4'h0);
    wr(OFS_TRIM_LO, 4'h0);
    measure(2, c);
    measure(16, c0);
    check("trim low", 16'(trim_o), 16'h0000);
    wr(OFS_TRIM_HI, 4'hf);
    wr(OFS_TRIM_LO, 4'hf);
    measure(2, c);
    measure(16, c1);
    check("trim high", 16'(trim_o), 16'h00ff);
    check("trim faster", 16'(c1 < c0), 16'h0001);
  endtask

  task automatic t_por();
    wr(OFS_TRIM_HI, 4'h3);
    wr(OFS_OPT2, 4'h1);
    do_reset();
    rd(OFS_TRIM_HI, 4'h7);
    rd(OFS_OPT2, 4'h0);
  endtask

  initial
  begin
    do_reset();
    t_reset_values();
    t_options();
    t_debounce();
    t_counter();
    t_freq();
    t_trim();
    t_por();
    final_report();
  end
endmodule
